// ### emai_consts.vh
`ifndef EMAI_CONSTS_VH
`define EMAI_CONSTS_VH
// acknowledge source encoding per region
`define EMAI_SRC_INT 1'b1
`define EMAI_SRC_EXT 1'b0
// default configuration
`define EMAI_SRC_RESET 4'h1
`define EMAI_ILOCK_RESET 1'b0
// bus error timeout: 1 ms at 25 ns
`define EMAI_TIMEOUT_NS 1000000
`define EMAI_CLK_NS 25
`define EMAI_TIMEOUT_CYC (`EMAI_TIMEOUT_NS / `EMAI_CLK_NS)
// internal acknowledge wait states
`define EMAI_INT_WAIT_RESET 4'h6
// base address register word address
`define EMAI_BAR_ADDR 24'h0000F2
`endif

// ### emai_sync.v
`timescale 1ns/1ps
`default_nettype none
module emai_sync
(
	input wire clk_sys, // clock
	input wire nrst, // async reset, active low
	input wire din, // asynchronous level
	output reg dout // synchronised level
);
	reg meta_q;
	// two-stage synchroniser; first stage is read only by the second
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_q <= 1'b0;
			dout <= 1'b0;
		end
		else
		begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule // emai_sync
`default_nettype wire

// ### emai_cfg.v
`timescale 1ns/1ps
`default_nettype none
`include "emai_consts.vh"
module emai_cfg
(
	input wire clk_sys, // clock
	input wire nrst, // async reset, active low
	input wire cfg_default, // pulse: return to default configuration
	input wire cfg_wr, // pulse: load settings
	input wire [3:0] cfg_src, // acknowledge source per region
	input wire cfg_ilock, // interlock setting
	output reg [3:0] src_q, // held sources, 1 = internal
	output reg ilock_q // held interlock enable
);
	// ----------------------------------------
	// configuration store
	// ----------------------------------------
	// per-region setting held
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			src_q <= `EMAI_SRC_RESET;
			ilock_q <= `EMAI_ILOCK_RESET;
		end
		else if (cfg_default)
		begin
			src_q <= `EMAI_SRC_RESET;
			ilock_q <= `EMAI_ILOCK_RESET;
		end
		else if (cfg_wr)
		begin
			src_q <= cfg_src;
			ilock_q <= cfg_ilock;
		end
	end
endmodule // emai_cfg
`default_nettype wire

// ### emai_top.v
`timescale 1ns/1ps
`default_nettype none
`include "emai_consts.vh"
module emai_top
(
	input wire clk_sys, // processor clock
	input wire nrst, // async reset, active low
	input wire cfg_default, // pulse: default configuration
	input wire cfg_wr, // pulse: load settings
	input wire [3:0] cfg_src, // per-region source, 1 = internal
	input wire cfg_ilock, // interlock setting
	input wire [3:0] cs_wait, // internal wait states for regions
	input wire emu_reset, // pulse: emulator reset command
	input wire cyc_start, // pulse: bus cycle begins
	input wire [23:0] cyc_addr, // cycle address
	input wire [3:0] cyc_cs, // decoded chip-select, one-hot
	input wire [3:0] cs_valid, // region initialised
	input wire cyc_emu, // cycle maps to emulation memory
	input wire in_exception, // processor is stacking an exception
	input wire monitor_entry, // pulse: break into monitor
	input wire bg_monitor, // background monitor active
	input wire transfer_ack_n_pin, // target acknowledge pin, active low
	input wire halt_n_pin, // target halt pin, active low
	output reg transfer_ack_n_o, // acknowledge drive value, low = ack
	output reg transfer_ack_oe_n, // acknowledge output enable, low = drive
	output reg bus_error_line_q, // bus error issued, one cycle
	output reg cyc_done_q, // cycle terminated, one cycle
	output reg halted_q, // processor halted
	output reg stack_pc_lo_q, // pulse: first bus-error action
	output reg bar_wr_q, // pulse: word write of base address
	output reg [23:0] bar_addr_q, // address for that write
	output reg refresh_lost_q, // built-in refresh not kept
	output reg [3:0] src_o_q, // active sources, status
	output reg ilock_o_q // active interlock, status
);
	localparam ST_IDLE = 2'b00;
	localparam ST_WAIT = 2'b01;
	localparam ST_BUS_ERROR_LINE = 2'b10;
	// derived count is integer wide; cut to the counter width on purpose
	localparam integer TMO_FULL = `EMAI_TIMEOUT_CYC;
	localparam [19:0] TMO = TMO_FULL[19:0];

	wire [3:0] src;
	wire ilock;
	wire ack_s;
	wire halt_s;
	reg [1:0] st_q;
	reg [1:0] st_d;
	reg [19:0] tmo_q;
	reg [3:0] wait_q;
	reg int_q;
	reg emu_q;
	reg valid_q;
	reg in_exc_q;
	reg bar_pend_q;

	// selects the per-region bit of a one-hot chip-select
	function sel_bit;
		input [3:0] cs;
		input [3:0] v;
		begin
			sel_bit = |(cs & v);
		end
	endfunction

	// ----------------------------------------
	// configuration and pin synchronisers
	// ----------------------------------------
	emai_cfg u_cfg
	(
		.clk_sys(clk_sys),
		.nrst(nrst),
		.cfg_default(cfg_default),
		.cfg_wr(cfg_wr),
		.cfg_src(cfg_src),
		.cfg_ilock(cfg_ilock),
		.src_q(src),
		.ilock_q(ilock)
	);
	// acknowledge pin is inverted so the synchroniser resets inactive
	emai_sync u_ack
	(
		.clk_sys(clk_sys),
		.nrst(nrst),
		.din(~transfer_ack_n_pin),
		.dout(ack_s)
	);
	emai_sync u_halt
	(
		.clk_sys(clk_sys),
		.nrst(nrst),
		.din(~halt_n_pin),
		.dout(halt_s)
	);

	// ----------------------------------------
	// cycle termination state machine
	// ----------------------------------------
	// next-state logic
	always @*
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:
				if (cyc_start && !halted_q)
					st_d = ST_WAIT;
			ST_WAIT:
				if (tmo_q == TMO - 20'h00001)
					st_d = ST_BUS_ERROR_LINE;
				else if (int_q && valid_q && wait_q == 4'h0)
					st_d = ST_IDLE;
				else if (emu_q && !int_q && ilock)
					st_d = ack_s ? ST_IDLE : ST_WAIT;
				else if (emu_q && !int_q)
					st_d = ST_IDLE;
				else if (!int_q && ack_s)
					st_d = ST_IDLE;
			ST_BUS_ERROR_LINE:
				st_d = ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
	end

	// cycle context, counters and terminations
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= ST_IDLE;
			tmo_q <= 20'h00000;
			wait_q <= 4'h0;
			int_q <= 1'b0;
			emu_q <= 1'b0;
			valid_q <= 1'b0;
			cyc_done_q <= 1'b0;
			bus_error_line_q <= 1'b0;
			transfer_ack_n_o <= 1'b1;
			transfer_ack_oe_n <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
			cyc_done_q <= 1'b0;
			bus_error_line_q <= 1'b0;
			transfer_ack_n_o <= 1'b1;
			transfer_ack_oe_n <= 1'b1;
			if (st_q == ST_IDLE && st_d == ST_WAIT)
			begin
				int_q <= sel_bit(cyc_cs, src);
				emu_q <= cyc_emu;
				valid_q <= sel_bit(cyc_cs, cs_valid);
				wait_q <= cs_wait;
				tmo_q <= 20'h00000;
			end
			else if (st_q == ST_WAIT)
			begin
				tmo_q <= tmo_q + 20'h00001;
				if (wait_q != 4'h0)
					wait_q <= wait_q - 4'h1;
			end
			if (st_q == ST_WAIT && st_d == ST_IDLE)
			begin
				cyc_done_q <= 1'b1;
				// internal acknowledge drives the open-drain line low
				if (int_q)
				begin
					transfer_ack_n_o <= 1'b0;
					transfer_ack_oe_n <= 1'b0;
				end
			end
			if (st_q == ST_BUS_ERROR_LINE)
				bus_error_line_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// double bus fault and halt
	// ----------------------------------------
	// halt pin only sampled, never driven
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			halted_q <= 1'b0;
			in_exc_q <= 1'b0;
			stack_pc_lo_q <= 1'b0;
		end
		else
		begin
			stack_pc_lo_q <= 1'b0;
			if (emu_reset)
			begin
				halted_q <= 1'b0;
				in_exc_q <= 1'b0;
			end
			else if (st_q == ST_BUS_ERROR_LINE && (in_exc_q || in_exception))
				halted_q <= 1'b1;
			else if (st_q == ST_BUS_ERROR_LINE)
			begin
				in_exc_q <= 1'b1;
				// first stack the pc low word
				stack_pc_lo_q <= 1'b1;
			end
			else if (!in_exception && st_q == ST_IDLE)
				in_exc_q <= 1'b0;
			// a halt event in the clear cycle wins over the clear
			if (halt_s || (emu_reset && st_q == ST_BUS_ERROR_LINE && (in_exc_q || in_exception)))
				halted_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// monitor entry: base address rewrite
	// ----------------------------------------
	// single word write so no refresh splits the two bytes
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			bar_pend_q <= 1'b0;
			bar_wr_q <= 1'b0;
			bar_addr_q <= 24'h000000;
			refresh_lost_q <= 1'b0;
			src_o_q <= `EMAI_SRC_RESET;
			ilock_o_q <= `EMAI_ILOCK_RESET;
		end
		else
		begin
			bar_pend_q <= monitor_entry;
			bar_wr_q <= bar_pend_q;
			bar_addr_q <= `EMAI_BAR_ADDR;
			refresh_lost_q <= bg_monitor;
			src_o_q <= src;
			ilock_o_q <= ilock;
		end
	end
endmodule // emai_top
`default_nettype wire

// ### emai_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module emai_monitor
(
	input wire logic clk_sys, // clk
	input wire logic nrst, // reset
	input wire logic emu_reset, // clear
	input wire logic monitor_entry, // entry
	input wire logic bg_monitor, // bg
	input wire logic in_exception, // exc
	input wire logic halt_n_pin, // halt
	input wire logic transfer_ack_n_o, // ack
	input wire logic transfer_ack_oe_n, // oe
	input wire logic bus_error_line_q, // bus_error_line
	input wire logic cyc_done_q, // done
	input wire logic halted_q, // halted
	input wire logic bar_wr_q, // bar wr
	input wire logic [23:0] bar_addr_q, // bar addr
	input wire logic refresh_lost_q // refresh
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// ack only driven low with the cycle end
	a_ack_with_done: assert property (!transfer_ack_oe_n |-> cyc_done_q && !transfer_ack_n_o) else $error("ack");
	// done stands one cycle
	a_done_one_cycle: assert property (cyc_done_q |=> !cyc_done_q) else $error("done");
	a_bar_on_entry: assert property (monitor_entry |-> ##[1:3] bar_wr_q) else $error("bar");
	a_bar_word_addr: assert property (bar_wr_q |-> bar_addr_q == 24'h0000F2) else $error("bar addr");
	a_refresh_follows: assert property (refresh_lost_q == $past(bg_monitor)) else $error("refresh");
	a_halt_holds: assert property (halted_q && !emu_reset && !$past(emu_reset) |=> halted_q) else $error("hold");
	a_fault_halts: assert property (bus_error_line_q && in_exception |-> ##[0:2] halted_q) else $error("fault");
	a_pin_halts: assert property ($fell(halt_n_pin) |-> ##[1:5] halted_q) else $error("pin");
endmodule // emai_monitor
`default_nettype wire

// ### emai_tgt.sv
`timescale 1ns/1ps
`default_nettype none
module emai_tgt
(
	input wire logic clk_sys, // clk
	input wire logic nrst, // reset
	input wire logic cyc_start, // start
	input wire logic cyc_done_q, // end
	input wire logic en, // answer cycles
	input wire logic halt_req, // pull halt
	input wire logic [3:0] waits, // wait states
	output logic transfer_ack_n_pin, // ack pin
	output logic halt_n_pin // halt pin
);
	logic [3:0] cnt_q;
	logic act_q;
	// acknowledge after waits
	// driven high again when the cycle ends, so idle reads high
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= 4'h0;
			act_q <= 1'b0;
			transfer_ack_n_pin <= 1'b1;
		end
		else
		begin
			if (cyc_start && en)
			begin
				act_q <= 1'b1;
				cnt_q <= waits;
			end
			else if (act_q && cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
			else if (act_q)
				transfer_ack_n_pin <= 1'b0;
			if (cyc_done_q)
			begin
				act_q <= 1'b0;
				transfer_ack_n_pin <= 1'b1;
			end
		end
	end
	assign halt_n_pin = !halt_req;
endmodule // emai_tgt
`default_nettype wire

// ### emai_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define TB_CHK(nm, e, a) begin checks_done++; if ((e) !== (a)) begin fails++; $display("Error %s exp %h got %h", nm, e, a); end end
module testbench;
	logic clk_sys = 0, nrst = 0, cfg_default = 0, cfg_wr = 0, cfg_ilock = 0, emu_reset = 0, cyc_start = 0;
	logic cyc_emu = 0, in_exception = 0, monitor_entry = 0, bg_monitor = 0, en = 1, halt_req = 0;
	logic [3:0] cfg_src = 4'h0, cs_wait = 4'h0, cyc_cs = 4'h1, cs_valid = 4'hF;
	logic [23:0] cyc_addr = 24'h000400;
	wire ack_pin, halt_pin, ack_o, ack_oe, bus_error_line, done, halted, stk, barw, refl, ilk;
	wire [23:0] bara;
	wire [3:0] srco;
	int fails = 0, checks_done = 0, lat;
	logic ak, be, sk;
	always #12.5 clk_sys = ~clk_sys;
	emai_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .cfg_default(cfg_default), .cfg_wr(cfg_wr), .cfg_src(cfg_src),
		.cfg_ilock(cfg_ilock), .cs_wait(cs_wait), .emu_reset(emu_reset), .cyc_start(cyc_start), .cyc_addr(cyc_addr),
		.cyc_cs(cyc_cs), .cs_valid(cs_valid), .cyc_emu(cyc_emu), .in_exception(in_exception),
		.monitor_entry(monitor_entry), .bg_monitor(bg_monitor), .transfer_ack_n_pin(ack_pin), .halt_n_pin(halt_pin),
		.transfer_ack_n_o(ack_o), .transfer_ack_oe_n(ack_oe), .bus_error_line_q(bus_error_line), .cyc_done_q(done),
		.halted_q(halted), .stack_pc_lo_q(stk), .bar_wr_q(barw), .bar_addr_q(bara), .refresh_lost_q(refl),
		.src_o_q(srco), .ilock_o_q(ilk));
	emai_tgt i_tgt (.clk_sys(clk_sys), .nrst(nrst), .cyc_start(cyc_start), .cyc_done_q(done), .en(en),
		.halt_req(halt_req), .waits(4'h5), .transfer_ack_n_pin(ack_pin), .halt_n_pin(halt_pin));
	task complete_run;
	begin
		if (fails == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	// one bus cycle: edges until it ends, internal ack seen, bus error seen
	task cyc(input logic [3:0] cs, input logic emu);
	begin
		cyc_cs = cs;
		cyc_emu = emu;
		cyc_start = 1;
		@(posedge clk_sys) #1 cyc_start = 0;
		lat = 0;
		while (done !== 1'b1 && bus_error_line !== 1'b1 && lat < 50000)
		begin
			@(posedge clk_sys) #1 lat++;
		end
		ak = (ack_oe === 1'b0 && ack_o === 1'b0);
		be = (bus_error_line === 1'b1);
		sk = (stk === 1'b1);
		@(posedge clk_sys) #1;
	end
	endtask
	// pulse a one-cycle input
	task automatic pulse(ref logic s);
	begin
		s = 1;
		@(posedge clk_sys) #1 s = 0;
		repeat (6) @(posedge clk_sys);
		#1;
	end
	endtask
	// long span covers both bus-error timeouts
	initial
	begin
		#(25 * 90000);
		fails++;
		complete_run;
	end
	initial
	begin
		repeat (20) @(posedge clk_sys);
		#1 nrst = 1;
		`TB_CHK("src", 4'h1, srco)
		`TB_CHK("ilock", 1'b0, ilk)
		cyc(4'h1, 0);
		`TB_CHK("int lat", 1, lat)
		`TB_CHK("int ack", 1'b1, ak)
		cyc(4'h2, 1);
		`TB_CHK("emu lat", 1, lat)
		cfg_src = 4'h3;
		cs_wait = 4'h3;
		pulse(cfg_wr);
		cyc(4'h2, 0);
		`TB_CHK("cs1 lat", 4, lat)
		`TB_CHK("cs1 ack", 1'b1, ak)
		cfg_src = 4'h1;
		cfg_ilock = 1;
		pulse(cfg_wr);
		cyc(4'h2, 1);
		`TB_CHK("ilk lat", 1'b1, lat > 7 && lat < 14)
		`TB_CHK("ilk ack", 1'b0, ak)
		pulse(cfg_default);
		`TB_CHK("dflt", 5'h02, {srco, ilk})
		bg_monitor = 1;
		monitor_entry = 1;
		@(posedge clk_sys) #1 monitor_entry = 0;
		@(posedge clk_sys) #1;
		`TB_CHK("bar wr", 1'b1, barw)
		`TB_CHK("bar addr", 24'h0000F2, bara)
		`TB_CHK("refresh", 1'b1, refl)
		bg_monitor = 0;
		halt_req = 1;
		repeat (5) @(posedge clk_sys);
		#1 halt_req = 0;
		`TB_CHK("pin halt", 1'b1, halted)
		repeat (5) @(posedge clk_sys);
		#1;
		`TB_CHK("halt kept", 1'b1, halted)
		pulse(emu_reset);
		`TB_CHK("halt clr", 1'b0, halted)
		en = 0;
		cs_valid = 4'h1;
		cyc(4'h4, 0);
		`TB_CHK("bus_error_line one", 1'b1, be)
		`TB_CHK("stack pc", 1'b1, sk)
		`TB_CHK("no halt", 1'b0, halted)
		in_exception = 1;
		cyc(4'h4, 0);
		`TB_CHK("bus_error_line", 1'b1, be)
		`TB_CHK("tmo", 1'b1, lat >= 39999 && lat <= 40002)
		`TB_CHK("dbl fault", 1'b1, halted)
		nrst = 0;
		#30 nrst = 1;
		`TB_CHK("rst clr", 1'b0, halted)
		complete_run;
	end
endmodule // testbench
bind emai_top emai_monitor i_mon (.clk_sys(clk_sys), .nrst(nrst), .emu_reset(emu_reset),
	.monitor_entry(monitor_entry), .bg_monitor(bg_monitor), .in_exception(in_exception), .halt_n_pin(halt_n_pin),
	.transfer_ack_n_o(transfer_ack_n_o), .transfer_ack_oe_n(transfer_ack_oe_n), .bus_error_line_q(bus_error_line_q),
	.cyc_done_q(cyc_done_q), .halted_q(halted_q), .bar_wr_q(bar_wr_q), .bar_addr_q(bar_addr_q),
	.refresh_lost_q(refresh_lost_q));
`default_nettype wire
